// file: src/dpr_pkg.sv
/*
 * Constants, opcodes and state type of the dual pot command decoder.
 * Assumes a 50 MHz system clock and a master that clocks the serial bus.
 */
package dpr_pkg;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned NV_WRITE_US = 10000; // Longest write, 10 ms
    localparam int unsigned NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
    localparam int POT_NUM = 2;
    localparam int REG_NUM = 4;
    localparam logic [3:0] DEV_TYPE_ID = 4'h9; // Arbitrary value
    localparam int OP_LSB = 4;
    localparam int RP_LSB = 2;
    localparam int PS_POS = 0;
    localparam int ADDR_LSB = 0;
    localparam int SY_SCL = 7;
    localparam int SY_SDA = 6;
    localparam int SY_TGL = 5;
    localparam int SY_BIT = 4;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [5:0] WIPER_TOP = 6'h3f;
    localparam logic [5:0] WIPER_BOTTOM = 6'h00;
    localparam logic [1:0] POWER_UP_REG = 2'h0;
    localparam logic [1:0] TX_PAD = 2'h0;
    localparam logic [3:0] OP_RD_WCR = 4'h9;
    localparam logic [3:0] OP_WR_WCR = 4'ha;
    localparam logic [3:0] OP_RD_DR = 4'hb;
    localparam logic [3:0] OP_WR_DR = 4'hc;
    localparam logic [3:0] OP_DR2WCR = 4'hd;
    localparam logic [3:0] OP_WCR2DR = 4'he;
    localparam logic [3:0] OP_G_DR2WCR = 4'h1;
    localparam logic [3:0] OP_G_WCR2DR = 4'h8;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_TX, ST_STEP, ST_DONE
    } dpr_state_t;
endpackage : dpr_pkg

// file: src/dpr_decoder.sv
/*
 * Command decoder and registers of a dual digital potentiometer.
 * Assumes SCL high and low phases of at least 5 i_clk periods each,
 * and SCL toggling while i_nrst is low.
 */
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Opcode 9 returns selected wiper counter
// RQ2 - Opcode a loads data into wiper counter
// RQ3 - Opcode b returns selected stored value
// RQ4 - Opcode c writes selected stored value
// RQ5 - Opcode d copies stored value to wiper
// RQ6 - Opcode e copies wiper to stored value
// RQ7 - Opcode 1 copies stored values, both pots
// RQ8 - Opcode 8 copies both wipers to stores
// RQ9 - Opcode 2 enables wiper stepping
// RQ10 - Each step moves wiper exactly one
// RQ11 - Six-bit wiper decodes one of 64 taps
// RQ12 - Power-up loads wiper from register zero
// RQ13 - Wiper counter is volatile
// RQ14 - Four nonvolatile stored values per pot
// RQ15 - Nonvolatile write completes within 10 ms
// RQ16 - Pot select bit picks the pot
// RQ17 - Acknowledge only on full address match
// RQ18 - Data high steps up, low steps down
// RQ19 - No address acknowledge while writing
// RQ20 - Acknowledge address, command and data bytes
// RQ21 - Wiper saturates at 0 and 63
// RQ22 - Unknown opcode changes nothing
module dpr_decoder #(
    parameter int unsigned NV_WRITE_CYCLES = dpr_pkg::NV_WRITE_CYC // Write length
) (
    input logic i_clk, // System clock
    input logic i_nrst, // Power-up reset, low active
    input logic i_scl, // Serial clock from master
    input logic i_sda, // Serial data pin level
    input logic [3:0] i_dev_addr, // Device address inputs
    output logic o_sda, // Serial data drive value
    output logic o_sda_oe_n, // Low while driving data
    output logic [5:0] o_wiper_pos0, // Wiper counter, pot 0
    output logic [5:0] o_wiper_pos1, // Wiper counter, pot 1
    output logic [63:0] o_tap0, // One-hot tap, pot 0
    output logic [63:0] o_tap1, // One-hot tap, pot 1
    output logic o_nv_busy // Nonvolatile write running
);
    localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);

    // ************
    // Link domain
    // ************
    logic [1:0] lk_rst_n;
    logic lk_tgl;
    logic lk_bit;

    always_ff @(posedge i_scl) begin
        lk_rst_n <= {lk_rst_n[0], i_nrst};
    end

    // Each rising SCL edge out of link reset flips the toggle, and every edge holds the sampled bit
    always_ff @(posedge i_scl) begin
        lk_bit <= i_sda;
        lk_tgl <= lk_rst_n[1] & ~lk_tgl;
    end

    // ************
    // Pin sampling
    // ************
    logic [7:0] sy_m;
    logic [7:0] sy_s;
    logic scl_q;
    logic sda_q;
    logic tgl_q;

    always_ff @(posedge i_clk) begin
        sy_m <= {i_scl, i_sda, lk_tgl, lk_bit, i_dev_addr};
        sy_s <= sy_m;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tgl_q <= 1'b0;
        end else begin
            scl_q <= sy_s[dpr_pkg::SY_SCL];
            sda_q <= sy_s[dpr_pkg::SY_SDA];
            tgl_q <= sy_s[dpr_pkg::SY_TGL];
        end
    end

    logic start;
    logic stop;
    logic scl_fall;
    logic bit_ev;
    logic rx_bit;
    assign start = scl_q & sy_s[dpr_pkg::SY_SCL] & sda_q & ~sy_s[dpr_pkg::SY_SDA];
    assign stop = scl_q & sy_s[dpr_pkg::SY_SCL] & ~sda_q & sy_s[dpr_pkg::SY_SDA];
    assign scl_fall = scl_q & ~sy_s[dpr_pkg::SY_SCL];
    assign bit_ev = (sy_s[dpr_pkg::SY_TGL] ^ tgl_q) & ~start & ~stop;
    assign rx_bit = sy_s[dpr_pkg::SY_BIT];

    // ************
    // Byte decode
    // ************
    dpr_pkg::dpr_state_t state;
    dpr_pkg::dpr_state_t cmd_next;
    logic [3:0] cnt;
    logic [6:0] sh;
    logic ack_pend;
    logic [7:0] byte_b;
    logic [3:0] c_op;
    logic [1:0] c_rp;
    logic c_ps;
    logic c_ok;
    logic [3:0] op;
    logic [1:0] rp;
    logic ps;
    logic [7:0] tx;
    logic [5:0] wiper_position_counter [dpr_pkg::POT_NUM];
    logic [5:0] dr [dpr_pkg::POT_NUM][dpr_pkg::REG_NUM];
    logic [63:0] tap [dpr_pkg::POT_NUM];
    logic [NVW-1:0] nv_cnt;
    logic [NVW-1:0] next_nv_cnt;
    logic nv_pend;

    assign byte_b = {sh, rx_bit};
    assign c_op = byte_b[dpr_pkg::OP_LSB +: 4];
    assign c_rp = byte_b[dpr_pkg::RP_LSB +: 2];
    assign c_ps = byte_b[dpr_pkg::PS_POS];

    logic byte_ev;
    logic cmd_ev;
    logic bad_ev;
    logic data_ev;
    logic step_ev;
    logic addr_ok;
    logic nv_set;
    logic [5:0] data_val;
    logic [5:0] wcr_sel;
    assign byte_ev = bit_ev && cnt == dpr_pkg::LAST_BIT
        && state != dpr_pkg::ST_IDLE && state != dpr_pkg::ST_STEP;
    assign cmd_ev = byte_ev && state == dpr_pkg::ST_CMD && c_ok;
    assign bad_ev = byte_ev && state == dpr_pkg::ST_CMD && !c_ok;
    assign data_ev = byte_ev && state == dpr_pkg::ST_DATA;
    assign step_ev = bit_ev && state == dpr_pkg::ST_STEP && cnt != dpr_pkg::ACK_CNT;
    assign addr_ok = c_op == dpr_pkg::DEV_TYPE_ID && nv_cnt == '0 // see RQ19
        && byte_b[dpr_pkg::ADDR_LSB +: 4] == sy_s[3:0]; // see RQ17
    assign nv_set = (cmd_ev && (c_op == dpr_pkg::OP_WCR2DR || c_op == dpr_pkg::OP_G_WCR2DR))
        || (data_ev && op == dpr_pkg::OP_WR_DR);
    assign data_val = byte_b[5:0];
    assign wcr_sel = wiper_position_counter[ps];

    // Opcode legality and follow-on phase
    always_comb begin
        unique case (c_op)
            dpr_pkg::OP_RD_WCR, dpr_pkg::OP_WR_WCR, dpr_pkg::OP_INCDEC: begin
                c_ok = (c_rp == 2'h0);
            end
            dpr_pkg::OP_RD_DR, dpr_pkg::OP_WR_DR, dpr_pkg::OP_DR2WCR, dpr_pkg::OP_WCR2DR: begin
                c_ok = 1'b1;
            end
            dpr_pkg::OP_G_DR2WCR, dpr_pkg::OP_G_WCR2DR: begin
                c_ok = !c_ps;
            end
            default: begin
                c_ok = 1'b0; // see RQ22
            end
        endcase
    end

    always_comb begin
        unique case (c_op)
            dpr_pkg::OP_RD_WCR, dpr_pkg::OP_RD_DR: begin
                cmd_next = dpr_pkg::ST_TX;
            end
            dpr_pkg::OP_WR_WCR, dpr_pkg::OP_WR_DR: begin
                cmd_next = dpr_pkg::ST_DATA;
            end
            dpr_pkg::OP_INCDEC: begin
                cmd_next = dpr_pkg::ST_STEP; // see RQ9
            end
            default: begin
                cmd_next = dpr_pkg::ST_DONE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state <= dpr_pkg::ST_IDLE;
            cnt <= 4'h0;
            ack_pend <= 1'b0;
        end else if (start) begin
            state <= dpr_pkg::ST_ADDR;
            cnt <= 4'h0;
            ack_pend <= 1'b0;
        end else if (stop) begin
            state <= dpr_pkg::ST_IDLE;
            ack_pend <= 1'b0;
        end else if (bit_ev && state != dpr_pkg::ST_IDLE) begin
            if (cnt == dpr_pkg::ACK_CNT) begin
                cnt <= 4'h0;
                ack_pend <= 1'b0;
                if (state == dpr_pkg::ST_TX && !ack_pend) begin
                    state <= dpr_pkg::ST_IDLE;
                end
            end else if (state != dpr_pkg::ST_STEP) begin
                cnt <= cnt + 4'h1;
                if (cnt == dpr_pkg::LAST_BIT) begin
                    unique case (state)
                        dpr_pkg::ST_ADDR: begin
                            ack_pend <= addr_ok; // see RQ20
                            state <= addr_ok ? dpr_pkg::ST_CMD : dpr_pkg::ST_IDLE;
                        end
                        dpr_pkg::ST_CMD: begin
                            ack_pend <= c_ok;
                            state <= c_ok ? cmd_next : dpr_pkg::ST_IDLE;
                        end
                        dpr_pkg::ST_DATA: begin
                            ack_pend <= 1'b1;
                            state <= dpr_pkg::ST_DONE;
                        end
                        dpr_pkg::ST_IDLE, dpr_pkg::ST_TX, dpr_pkg::ST_STEP,
                        dpr_pkg::ST_DONE: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sh <= 7'h00;
        end else if (bit_ev) begin
            sh <= byte_b[6:0];
        end
    end

    // Step lands on the SCL fall, so the clock of a stop never steps
    logic step_pend;
    logic step_up;
    logic step_go;
    assign step_go = step_pend & scl_fall;

    always_ff @(posedge i_clk) begin
        if (!i_nrst || start || stop) begin
            step_pend <= 1'b0;
            step_up <= 1'b0;
        end else if (step_ev) begin
            step_pend <= 1'b1;
            step_up <= rx_bit; // see RQ18
        end else if (scl_fall) begin
            step_pend <= 1'b0;
        end
    end

    // Command fields and read data, latched on an accepted command
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            op <= 4'h0;
            rp <= 2'h0;
            ps <= 1'b0;
            tx <= 8'h00;
        end else if (cmd_ev) begin
            op <= c_op;
            rp <= c_rp;
            ps <= c_ps; // see RQ16
            tx <= {dpr_pkg::TX_PAD, (c_op == dpr_pkg::OP_RD_DR) ? dr[c_ps][c_rp]
                : wiper_position_counter[c_ps]}; // see RQ1, see RQ3
        end
    end

    // ************
    // Pot registers
    // ************
    for (genvar g = 0; g < dpr_pkg::POT_NUM; g++) begin : g_pot
        always_ff @(posedge i_clk) begin
            if (!i_nrst) begin
                wiper_position_counter[g] <= dr[g][dpr_pkg::POWER_UP_REG]; // see RQ12, see RQ13
            end else if (cmd_ev && (c_op == dpr_pkg::OP_G_DR2WCR
                    || (c_op == dpr_pkg::OP_DR2WCR && c_ps == 1'(g)))) begin
                wiper_position_counter[g] <= dr[g][c_rp]; // see RQ5, see RQ7
            end else if (data_ev && op == dpr_pkg::OP_WR_WCR && ps == 1'(g)) begin
                wiper_position_counter[g] <= data_val; // see RQ2
            end else if (step_go && ps == 1'(g)) begin
                if (step_up && wiper_position_counter[g] != dpr_pkg::WIPER_TOP) begin
                    wiper_position_counter[g] <= wiper_position_counter[g] + 6'h01; // see RQ10, see RQ18
                end else if (!step_up && wiper_position_counter[g] != dpr_pkg::WIPER_BOTTOM) begin
                    wiper_position_counter[g] <= wiper_position_counter[g] - 6'h01; // see RQ21
                end
            end
        end

        // Nonvolatile, so no reset
        always_ff @(posedge i_clk) begin
            if (cmd_ev && (c_op == dpr_pkg::OP_G_WCR2DR
                    || (c_op == dpr_pkg::OP_WCR2DR && c_ps == 1'(g)))) begin
                dr[g][c_rp] <= wiper_position_counter[g]; // see RQ6, see RQ8
            end else if (data_ev && op == dpr_pkg::OP_WR_DR && ps == 1'(g)) begin
                dr[g][rp] <= data_val; // see RQ4, see RQ14
            end
        end

        always_ff @(posedge i_clk) begin
            tap[g] <= 64'h1 << wiper_position_counter[g]; // see RQ11
        end
    end

    assign o_wiper_pos0 = wiper_position_counter[0];
    assign o_wiper_pos1 = wiper_position_counter[1];
    assign o_tap0 = tap[0];
    assign o_tap1 = tap[1];

    // ************
    // Write timer
    // ************
    always_ff @(posedge i_clk) begin
        if (!i_nrst || stop) begin
            nv_pend <= 1'b0;
        end else if (nv_set) begin
            nv_pend <= 1'b1;
        end
    end

    // Write cycle starts at the stop that ends the command
    always_comb begin
        next_nv_cnt = nv_cnt;
        if (stop && nv_pend) begin
            next_nv_cnt = NVW'(NV_WRITE_CYCLES); // see RQ15
        end else if (nv_cnt != '0) begin
            next_nv_cnt = nv_cnt - NVW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            nv_cnt <= '0;
            o_nv_busy <= 1'b0;
        end else begin
            nv_cnt <= next_nv_cnt;
            o_nv_busy <= next_nv_cnt != '0;
        end
    end

    // ************
    // Data pin
    // ************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_sda <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (start || stop) begin
            o_sda_oe_n <= 1'b1;
        end else if (scl_fall) begin
            o_sda_oe_n <= !(ack_pend || (state == dpr_pkg::ST_TX // see RQ20
                && cnt < dpr_pkg::ACK_CNT && !tx[3'h7 - cnt[2:0]]));
        end
    end

    // ************
    // Assertions
    // ************
    default clocking dpr_cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_rd_wcr;
        cmd_ev && c_op == dpr_pkg::OP_RD_WCR |=> tx == {dpr_pkg::TX_PAD, wcr_sel};
    endproperty
    a_rd_wcr: assert property (p_rd_wcr) else $error("wiper read data wrong"); // see RQ1
    property p_wr_wcr;
        data_ev && op == dpr_pkg::OP_WR_WCR |=> wcr_sel == $past(data_val);
    endproperty
    a_wr_wcr: assert property (p_wr_wcr) else $error("wiper write lost"); // see RQ2
    property p_rd_dr;
        cmd_ev && c_op == dpr_pkg::OP_RD_DR |=> tx[5:0] == dr[ps][rp] && state == dpr_pkg::ST_TX;
    endproperty
    a_rd_dr: assert property (p_rd_dr) else $error("stored read data wrong"); // see RQ3
    property p_wr_dr;
        data_ev && op == dpr_pkg::OP_WR_DR |=> dr[ps][rp] == $past(data_val) && nv_pend;
    endproperty
    a_wr_dr: assert property (p_wr_dr) else $error("stored write lost"); // see RQ4
    property p_dr2wcr;
        cmd_ev && c_op == dpr_pkg::OP_DR2WCR |=> wcr_sel == dr[ps][rp];
    endproperty
    a_dr2wcr: assert property (p_dr2wcr) else $error("transfer to wiper wrong"); // see RQ5
    property p_wcr2dr;
        cmd_ev && c_op == dpr_pkg::OP_WCR2DR |=> dr[ps][rp] == wcr_sel;
    endproperty
    a_wcr2dr: assert property (p_wcr2dr) else $error("transfer to store wrong"); // see RQ6
    property p_g_dr2wcr;
        cmd_ev && c_op == dpr_pkg::OP_G_DR2WCR |=> wiper_position_counter[0] == dr[0][rp] && wiper_position_counter[1] == dr[1][rp];
    endproperty
    a_g_dr2wcr: assert property (p_g_dr2wcr) else $error("global load wrong"); // see RQ7
    property p_g_wcr2dr;
        cmd_ev && c_op == dpr_pkg::OP_G_WCR2DR |=> dr[0][rp] == wiper_position_counter[0] && dr[1][rp] == wiper_position_counter[1];
    endproperty
    a_g_wcr2dr: assert property (p_g_wcr2dr) else $error("global save wrong"); // see RQ8
    property p_step;
        step_go && step_up && wcr_sel != dpr_pkg::WIPER_TOP |=> wcr_sel == $past(wcr_sel) + 6'h01;
    endproperty
    a_step: assert property (p_step) else $error("step up wrong"); // see RQ10
    property p_sat;
        step_go && !step_up && wcr_sel == dpr_pkg::WIPER_BOTTOM |=> wcr_sel == dpr_pkg::WIPER_BOTTOM;
    endproperty
    a_sat: assert property (p_sat) else $error("wiper wrapped"); // see RQ21
    property p_addr;
        byte_ev && state == dpr_pkg::ST_ADDR && o_nv_busy |=> !ack_pend && state == dpr_pkg::ST_IDLE;
    endproperty
    a_addr: assert property (p_addr) else $error("acknowledged while busy"); // see RQ19
    property p_nv_time;
        stop && nv_pend |=> o_nv_busy && nv_cnt == NVW'(NV_WRITE_CYCLES);
    endproperty
    a_nv_time: assert property (p_nv_time) else $error("write timer wrong"); // see RQ15
    property p_ack;
        ack_pend && scl_fall && !start && !stop |=> !o_sda_oe_n;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not driven"); // see RQ20
    property p_bad;
        bad_ev |=> $stable(wiper_position_counter[0]) && $stable(wiper_position_counter[1]) && !ack_pend && !nv_pend;
    endproperty
    a_bad: assert property (p_bad) else $error("unknown opcode acted"); // see RQ22
endmodule : dpr_decoder

// file: verif/dpr_host_model.sv
/*
 * Two-wire bus master model: makes SCL and drives or releases SDA.
 * Assumes the data wire is resolved with a pull-up by the bench.
 */
`timescale 1ns/1ps
module dpr_host_model (
    input wire logic i_sda_line, // Resolved data wire
    output logic o_scl, // Serial clock
    output logic o_sda_drv // Data drive, 1 = released
);
    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end
    // Idle clock pulses, data released
    task automatic pulse_scl(input int n);
        repeat (n) begin
            #120 o_scl = 1'b0;
            #120 o_scl = 1'b1;
        end
    endtask : pulse_scl
    task automatic start_cond();
        #87 o_sda_drv = 1'b1;
        #80 o_scl = 1'b1;
        #80 o_sda_drv = 1'b0;
        #80 o_scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #80 o_sda_drv = 1'b0;
        #80 o_scl = 1'b1;
        #80 o_sda_drv = 1'b1;
        #80;
    endtask : stop_cond
    // Data held through the whole high phase
    task automatic bit_out(input logic b, output logic seen);
        #80 o_sda_drv = b;
        #80 o_scl = 1'b1;
        seen = i_sda_line;
        #120 o_scl = 1'b0;
    endtask : bit_out
    task automatic byte_out(input logic [7:0] d, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i], s);
        end
        bit_out(1'b1, s);
        acked = ~s;
    endtask : byte_out
    task automatic byte_in(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b1, s);
            d[i] = s;
        end
        bit_out(mack, s);
    endtask : byte_in
endmodule : dpr_host_model

// file: verif/dpr_decoder_tb.sv
/*
 * Self-checking bench of the dual pot command decoder.
 * Assumes the host model above and a pull-up on the data wire.
 */
`timescale 1ns/1ps
module dpr_decoder_tb;
    localparam int unsigned NV_CYC = 400;
    localparam logic [3:0] ADDR = 4'h6;
    logic i_clk;
    logic i_nrst;
    logic host_scl;
    logic host_sda;
    logic sda_line;
    logic o_sda;
    logic o_sda_oe_n;
    logic o_nv_busy;
    logic [5:0] o_wiper_pos0;
    logic [5:0] o_wiper_pos1;
    logic [63:0] o_tap0;
    logic [63:0] o_tap1;
    logic [5:0] dr_exp [2][4];
    logic [7:0] rd;
    logic ack;
    logic a;
    int bad_count = 0;
    int num_checks = 0;
    assign sda_line = host_sda & (o_sda_oe_n | o_sda);
    dpr_host_model i_host (
        .i_sda_line(sda_line),
        .o_scl(host_scl),
        .o_sda_drv(host_sda)
    );
    dpr_decoder #(.NV_WRITE_CYCLES(NV_CYC)) i_dut (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_scl(host_scl),
        .i_sda(sda_line),
        .i_dev_addr(ADDR),
        .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n),
        .o_wiper_pos0(o_wiper_pos0),
        .o_wiper_pos1(o_wiper_pos1),
        .o_tap0(o_tap0),
        .o_tap1(o_tap1),
        .o_nv_busy(o_nv_busy)
    );
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // ****************************************
    // Common tasks
    // ****************************************
    task automatic finish_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_nv_busy !== 1'b0 && n < NV_CYC + 100) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= NV_CYC + 100) begin
            bad_count++;
            $display("ERROR at %0t: busy never ended", $time);
            finish_test();
        end
    endtask : wait_idle
    // Kind 0 no data, 1 write byte, 2 read byte, 3 steps of count wd[7:1]
    task automatic frame(input logic [7:0] c, input int kind, input logic [7:0] wd);
        logic s;
        wait_idle();
        i_host.start_cond();
        i_host.byte_out({dpr_pkg::DEV_TYPE_ID, ADDR}, ack);
        i_host.byte_out(c, s);
        ack = ack & s;
        if (kind == 1) begin
            i_host.byte_out(wd, s);
            ack = ack & s;
        end
        if (kind == 2) begin
            i_host.byte_in(1'b1, rd);
        end
        if (kind == 3) begin
            repeat (wd[7:1]) i_host.bit_out(wd[0], s);
        end
        i_host.stop_cond();
        repeat (8) @(negedge i_clk);
    endtask : frame
    task automatic t_reset();
        i_nrst = 1'b0;
        i_host.pulse_scl(4);
        @(negedge i_clk);
        i_nrst = 1'b1;
        i_host.pulse_scl(2); // Link reset releases two SCL edges late
        repeat (5) @(negedge i_clk);
    endtask : t_reset
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_store_all();
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 4; r++) begin
                dr_exp[p][r] = 6'(p * 16 + r * 5 + 3);
                frame({dpr_pkg::OP_WR_DR, 2'(r), 1'b0, 1'(p)}, 1, {2'h0, dr_exp[p][r]});
                check({7'h0, ack}, 8'h1);
            end
        end
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 4; r++) begin
                frame({dpr_pkg::OP_RD_DR, 2'(r), 1'b0, 1'(p)}, 2, 8'h00);
                check(rd, {2'h0, dr_exp[p][r]});
            end
        end
    endtask : t_store_all
    task automatic t_busy_poll();
        dr_exp[1][3] = 6'h2c;
        frame({dpr_pkg::OP_WR_DR, 4'hd}, 1, 8'h2c);
        check({7'h0, o_nv_busy}, 8'h1);
        i_host.start_cond();
        i_host.byte_out({dpr_pkg::DEV_TYPE_ID, ADDR}, a);
        check({7'h0, a}, 8'h0);
        i_host.stop_cond();
    endtask : t_busy_poll
    task automatic t_wiper_rw();
        frame({dpr_pkg::OP_WR_WCR, 4'h1}, 1, 8'h15);
        check({7'h0, ack}, 8'h1);
        check({2'h0, o_wiper_pos1}, 8'h15);
        check({7'h0, o_tap1 === 64'h1 << 21}, 8'h1);
        frame({dpr_pkg::OP_RD_WCR, 4'h1}, 2, 8'h00);
        check(rd, 8'h15);
    endtask : t_wiper_rw
    task automatic t_xfer();
        frame({dpr_pkg::OP_DR2WCR, 4'h8}, 0, 8'h00);
        check({2'h0, o_wiper_pos0}, {2'h0, dr_exp[0][2]});
        dr_exp[1][1] = 6'h15;
        frame({dpr_pkg::OP_WCR2DR, 4'h5}, 0, 8'h00);
        frame({dpr_pkg::OP_RD_DR, 4'h5}, 2, 8'h00);
        check(rd, 8'h15);
    endtask : t_xfer
    task automatic t_global();
        frame({dpr_pkg::OP_G_DR2WCR, 4'hc}, 0, 8'h00);
        check({2'h0, o_wiper_pos0}, {2'h0, dr_exp[0][3]});
        check({2'h0, o_wiper_pos1}, {2'h0, dr_exp[1][3]});
        frame({dpr_pkg::OP_G_WCR2DR, 4'h8}, 0, 8'h00);
        for (int p = 0; p < 2; p++) begin
            frame({dpr_pkg::OP_RD_DR, 3'h4, 1'(p)}, 2, 8'h00);
            check(rd, {2'h0, dr_exp[p][3]});
        end
    endtask : t_global
    task automatic t_step();
        frame({dpr_pkg::OP_WR_WCR, 4'h0}, 1, 8'h3e);
        frame({dpr_pkg::OP_INCDEC, 4'h0}, 3, 8'h07);
        check({2'h0, o_wiper_pos0}, 8'h3f);
        check({7'h0, o_tap0 === 64'h1 << 63}, 8'h1);
        frame({dpr_pkg::OP_INCDEC, 4'h0}, 3, 8'h04);
        check({2'h0, o_wiper_pos0}, 8'h3d);
        frame({dpr_pkg::OP_WR_WCR, 4'h0}, 1, 8'h01);
        frame({dpr_pkg::OP_INCDEC, 4'h0}, 3, 8'h06);
        check({2'h0, o_wiper_pos0}, 8'h00);
    endtask : t_step
    task automatic t_refuse();
        logic [7:0] ops [9];
        ops = '{8'h01, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71, 8'hf1, 8'ha5, 8'h11};
        for (int i = 0; i < 9; i++) begin
            frame(ops[i], 1, 8'h2a);
            check({7'h0, ack}, 8'h0);
            check({2'h0, o_wiper_pos1}, {2'h0, dr_exp[1][3]});
        end
        i_host.start_cond();
        i_host.byte_out({dpr_pkg::DEV_TYPE_ID, ADDR ^ 4'h8}, a);
        check({7'h0, a}, 8'h0);
        i_host.stop_cond();
    endtask : t_refuse
    task automatic t_recall();
        t_reset();
        check({2'h0, o_wiper_pos0}, {2'h0, dr_exp[0][0]});
        check({2'h0, o_wiper_pos1}, {2'h0, dr_exp[1][0]});
    endtask : t_recall
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        i_nrst = 1'b0;
        t_reset();
        t_store_all();
        t_busy_poll();
        t_wiper_rw();
        t_xfer();
        t_global();
        t_step();
        t_refuse();
        t_recall();
        finish_test();
    end
    initial begin
        #1500us;
        bad_count++;
        $display("ERROR at %0t: run took too long", $time);
        finish_test();
    end
endmodule : dpr_decoder_tb
